// ===== logic/fci_filter_regs.vh
// Register offsets, field layouts, reset values and arithmetic constants of the filter code block
`ifndef FCI_FILTER_REGS_VH
`define FCI_FILTER_REGS_VH

`define FCI_ADDR_SEQ_STOP 15'h0011
`define FCI_ADDR_SEQ_START 15'h0012
`define FCI_ADDR_SEQ_DIR 15'h0013
`define FCI_ADDR_SEQ_PTR 15'h0014
`define FCI_ADDR_WR_CENTER 15'h0020
`define FCI_ADDR_WR_BW 15'h0021
`define FCI_ADDR_WR_MATCH 15'h0022
`define FCI_ADDR_COEF_BASE 15'h0030
`define FCI_ADDR_COEF_LAST 15'h003F
`define FCI_ADDR_INTERP 15'h0050
`define FCI_ADDR_RB_CENTER 15'h0060
`define FCI_ADDR_RB_BW 15'h0061
`define FCI_ADDR_RB_MATCH 15'h0062
`define FCI_ADDR_LUT_BASE 15'h0100
`define FCI_ADDR_LUT_LAST 15'h015F

`define FCI_RST_SEQ_STOP 7'h7F
`define FCI_RST_SEQ_START 7'h00
`define FCI_INTERP_BIT 0
`define FCI_DIR_BIT 0

// Coefficient slots: 0..9 centre, 10..12 bandwidth, 13..15 match
`define FCI_COEF_BW0 4'hA
`define FCI_COEF_BW1 4'hB
`define FCI_COEF_BW2 4'hC
`define FCI_COEF_MT0 4'hD
`define FCI_COEF_MT1 4'hE
`define FCI_COEF_MT2 4'hF
`define FCI_RST_COEF_0 8'hDA
`define FCI_RST_COEF_1 8'hB0
`define FCI_RST_COEF_2 8'h8E
`define FCI_RST_COEF_3 8'h66
`define FCI_RST_COEF_4 8'h4B
`define FCI_RST_COEF_5 8'h37
`define FCI_RST_COEF_6 8'h2A
`define FCI_RST_COEF_7 8'h20
`define FCI_RST_COEF_8 8'h18
`define FCI_RST_COEF_9 8'h13
`define FCI_RST_COEF_10 8'h01
`define FCI_RST_COEF_11 8'h05
`define FCI_RST_COEF_12 8'h27
`define FCI_RST_COEF_13 8'h05
`define FCI_RST_COEF_14 8'h19
`define FCI_RST_COEF_15 8'h8A

`define FCI_LO_SEG_END 8'h10
`define FCI_MID_SEG_END 8'h20
`define FCI_TOP_LOAD 8'hFF
`define FCI_LO_SHIFT 4
`define FCI_SEG_SHIFT 5
`define FCI_BM_KNEE 8'h20
`define FCI_BM_SCALE 32'h0000_0127
`define FCI_BM_SHIFT 16

`endif

// ===== logic/fci_filter_code_interp_sequencer.v
// Capacitor code interpolation engine and chip-select driven table sequencer
`timescale 1ns/10ps
`include "fci_filter_regs.vh"
module fci_filter_code_interp_sequencer (
    input wire ref_clk,
    input wire rst_n,
    input wire sequencer_mode_select,
    input wire cs_n,
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [14:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg [7:0] center_cap_code,
    output reg [7:0] bandwidth_cap_code,
    output reg [7:0] match_cap_code,
    output reg [6:0] sequence_pointer
);

    reg [7:0] coef [0:15];
    reg [7:0] lut [0:95];
    reg [6:0] sequence_stop_index;
    reg [6:0] sequence_start_index;
    reg sequence_direction;
    reg interp_enable;
    reg [7:0] wr_center;
    reg [7:0] wr_bw;
    reg [7:0] wr_match;
    reg [7:0] seq_center;
    reg [7:0] seq_bw;
    reg [7:0] seq_match;
    reg cs_n_q;
    reg [7:0] next_rdata;
    reg [6:0] next_pointer;

    wire cs_rise = cs_n & ~cs_n_q;
    // Entry base is three bytes per entry; pointers above 31 alias into the table
    wire [6:0] lut_base = {2'b00, sequence_pointer[4:0]} + {1'b0, sequence_pointer[4:0], 1'b0};
    wire [6:0] wr_lut_idx = reg_addr[6:0];
    wire lut_hit = (reg_addr >= `FCI_ADDR_LUT_BASE) && (reg_addr <= `FCI_ADDR_LUT_LAST);
    wire coef_hit = (reg_addr >= `FCI_ADDR_COEF_BASE) && (reg_addr <= `FCI_ADDR_COEF_LAST);
    wire coef_wr = reg_wr_en && coef_hit;
    wire lut_wr = reg_wr_en && lut_hit;

    // Source of the three load values: table entry while sequencing, write grouping otherwise
    // Moving the mode pin alone never moves the pointer; only a chip-select rise does
    wire [7:0] center_load_value = sequencer_mode_select ? seq_center : wr_center;
    wire [7:0] bw_load = sequencer_mode_select ? seq_bw : wr_bw;
    wire [7:0] match_load = sequencer_mode_select ? seq_match : wr_match;

    // Reset value of each coefficient slot
    // Nominal-bandwidth set, so interpolation is usable straight out of reset
    function [7:0] coef_default;
        input integer idx;
        begin
            case (idx)
                0: coef_default = `FCI_RST_COEF_0;
                1: coef_default = `FCI_RST_COEF_1;
                2: coef_default = `FCI_RST_COEF_2;
                3: coef_default = `FCI_RST_COEF_3;
                4: coef_default = `FCI_RST_COEF_4;
                5: coef_default = `FCI_RST_COEF_5;
                6: coef_default = `FCI_RST_COEF_6;
                7: coef_default = `FCI_RST_COEF_7;
                8: coef_default = `FCI_RST_COEF_8;
                9: coef_default = `FCI_RST_COEF_9;
                10: coef_default = `FCI_RST_COEF_10;
                11: coef_default = `FCI_RST_COEF_11;
                12: coef_default = `FCI_RST_COEF_12;
                13: coef_default = `FCI_RST_COEF_13;
                14: coef_default = `FCI_RST_COEF_14;
                default: coef_default = `FCI_RST_COEF_15;
            endcase
        end
    endfunction

    // Bandwidth and match curves share one shape; 32-bit signed keeps negative slopes exact
    // Inputs are eight bits, so the largest scaled product stays well inside 32 bits
    function [7:0] bm_curve;
        input [7:0] y;
        input [7:0] c0;
        input [7:0] c1;
        input [7:0] c2;
        reg signed [31:0] acc;
        begin
            acc = 32'sh0000_0000;
            if (y < `FCI_BM_KNEE) begin
                acc = $signed({24'h00_0000, c0}) + (($signed({24'h00_0000, y}) *
                    ($signed({24'h00_0000, c1}) - $signed({24'h00_0000, c0}))) >>> `FCI_SEG_SHIFT);
            end else if (y < `FCI_TOP_LOAD) begin
                acc = $signed({24'h00_0000, c1}) + (($signed({24'h00_0000, y - `FCI_BM_KNEE}) *
                    ($signed({24'h00_0000, c2}) - $signed({24'h00_0000, c1})) *
                    $signed(`FCI_BM_SCALE)) >>> `FCI_BM_SHIFT);
            end else begin
                acc = $signed({24'h00_0000, c2});
            end
            bm_curve = acc[7:0];
        end
    endfunction

    // Centre curve: pick segment, then interpolate from its upper end
    // Load 255 takes the last coefficient flat; 254 still interpolates toward 256
    reg [3:0] seg_hi_idx;
    reg [8:0] seg_end;
    reg seg_long;
    reg seg_flat;
    reg signed [9:0] seg_dist;
    reg signed [8:0] seg_diff;
    reg signed [19:0] seg_prod;
    reg signed [19:0] seg_sum;
    reg [7:0] interp_center;
    always @* begin
        seg_hi_idx = 4'h0;
        seg_end = {1'b0, `FCI_LO_SEG_END};
        seg_long = 1'b0;
        seg_flat = 1'b0;
        if (center_load_value < `FCI_LO_SEG_END) begin
            seg_hi_idx = 4'h0;
        end else if (center_load_value < `FCI_MID_SEG_END) begin
            seg_hi_idx = 4'h1;
            seg_end = {1'b0, `FCI_MID_SEG_END};
        end else if (center_load_value < `FCI_TOP_LOAD) begin
            // Segment k spans 32k..32k+31 and ends at 32(k+1); k=7 ends at 256
            seg_hi_idx = {1'b0, center_load_value[7:5]} + 4'h1;
            seg_end = {seg_hi_idx, 5'h00};
            seg_long = 1'b1;
        end else begin
            seg_flat = 1'b1;
        end
        seg_dist = $signed({1'b0, seg_end}) - $signed({2'b00, center_load_value});
        seg_diff = $signed({1'b0, coef[seg_hi_idx]}) - $signed({1'b0, coef[seg_hi_idx + 4'h1]});
        seg_prod = seg_dist * seg_diff;
        seg_sum = $signed({12'h000, coef[seg_hi_idx + 4'h1]}) +
            (seg_long ? (seg_prod >>> `FCI_SEG_SHIFT) : (seg_prod >>> `FCI_LO_SHIFT));
        interp_center = seg_flat ? coef[9] : seg_sum[7:0];
    end

    wire [7:0] interp_bw = bm_curve(interp_center, coef[`FCI_COEF_BW0],
        coef[`FCI_COEF_BW1], coef[`FCI_COEF_BW2]);
    wire [7:0] interp_match = bm_curve(interp_center, coef[`FCI_COEF_MT0],
        coef[`FCI_COEF_MT1], coef[`FCI_COEF_MT2]);

    // Applied capacitor codes, one cycle behind the load values
    // Registering them keeps decode glitches off the capacitor lines
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            center_cap_code <= 8'h00;
            bandwidth_cap_code <= 8'h00;
            match_cap_code <= 8'h00;
        end else if (interp_enable) begin
            center_cap_code <= interp_center;
            bandwidth_cap_code <= interp_bw;
            match_cap_code <= interp_match;
        end else begin
            center_cap_code <= center_load_value;
            bandwidth_cap_code <= bw_load;
            match_cap_code <= match_load;
        end
    end

    // Coefficient slots, one per generate entry so each keeps its own reset value
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_coef
            localparam [3:0] slot_idx = gi;
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    coef[gi] <= coef_default(gi);
                end else if (coef_wr && (reg_addr[3:0] == slot_idx)) begin
                    coef[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    // Table storage has no reset; software loads it before entering sequencing
    // Only the low seven address bits index it; the hit decode bounds the range
    always @(posedge ref_clk) begin
        if (lut_wr) begin
            lut[wr_lut_idx] <= reg_wdata;
        end
    end

    // Control and write-grouping registers
    // Reserved bits are dropped on write and read back as zero
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sequence_stop_index <= `FCI_RST_SEQ_STOP;
            sequence_start_index <= `FCI_RST_SEQ_START;
            sequence_direction <= 1'b0;
            interp_enable <= 1'b0;
            wr_center <= 8'h00;
            wr_bw <= 8'h00;
            wr_match <= 8'h00;
        end else if (reg_wr_en) begin
            case (reg_addr)
                `FCI_ADDR_SEQ_STOP: sequence_stop_index <= reg_wdata[6:0];
                `FCI_ADDR_SEQ_START: sequence_start_index <= reg_wdata[6:0];
                `FCI_ADDR_SEQ_DIR: sequence_direction <= reg_wdata[`FCI_DIR_BIT];
                `FCI_ADDR_INTERP: interp_enable <= reg_wdata[`FCI_INTERP_BIT];
                `FCI_ADDR_WR_CENTER: wr_center <= reg_wdata;
                `FCI_ADDR_WR_BW: wr_bw <= reg_wdata;
                `FCI_ADDR_WR_MATCH: wr_match <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Next pointer after a rise; reload when not sequencing
    // In direct mode a rise only reloads; no table entry is applied
    always @* begin
        if (!sequencer_mode_select) begin
            next_pointer = sequence_direction ?
                sequence_stop_index : sequence_start_index;
        end else if (!sequence_direction) begin
            next_pointer = (sequence_pointer == sequence_stop_index) ?
                sequence_start_index : sequence_pointer + 7'h01;
        end else begin
            next_pointer = (sequence_pointer == sequence_start_index) ?
                sequence_stop_index : sequence_pointer - 7'h01;
        end
    end

    // Sequencer: idle level of chip select is high, so no false rise out of reset
    // The entry is fetched with the old pointer, the one the pointer register showed
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_n_q <= 1'b1;
            sequence_pointer <= 7'h00;
            seq_center <= 8'h00;
            seq_bw <= 8'h00;
            seq_match <= 8'h00;
        end else begin
            cs_n_q <= cs_n;
            if (cs_rise) begin
                sequence_pointer <= next_pointer;
                if (sequencer_mode_select) begin
                    seq_center <= lut[lut_base];
                    seq_bw <= lut[lut_base + 7'h01];
                    seq_match <= lut[lut_base + 7'h02];
                end
            end
        end
    end

    // Read mux; unmapped addresses read zero, reserved bits zero
    always @* begin
        next_rdata = 8'h00;
        if (lut_hit) begin
            next_rdata = lut[wr_lut_idx];
        end else if (coef_hit) begin
            next_rdata = coef[reg_addr[3:0]];
        end else begin
            case (reg_addr)
                `FCI_ADDR_SEQ_STOP: next_rdata = {1'b0, sequence_stop_index};
                `FCI_ADDR_SEQ_START: next_rdata = {1'b0, sequence_start_index};
                `FCI_ADDR_SEQ_DIR: next_rdata = {7'h00, sequence_direction};
                `FCI_ADDR_SEQ_PTR: next_rdata = {1'b0, sequence_pointer};
                `FCI_ADDR_WR_CENTER: next_rdata = wr_center;
                `FCI_ADDR_WR_BW: next_rdata = wr_bw;
                `FCI_ADDR_WR_MATCH: next_rdata = wr_match;
                `FCI_ADDR_INTERP: next_rdata = {7'h00, interp_enable};
                `FCI_ADDR_RB_CENTER: next_rdata = center_cap_code;
                `FCI_ADDR_RB_BW: next_rdata = bandwidth_cap_code;
                `FCI_ADDR_RB_MATCH: next_rdata = match_cap_code;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Read data holds until the next read strobe
    // A read in the same cycle as a write returns the old contents
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd_en) begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // fci_filter_code_interp_sequencer

// ===== bench/fci_host_model.sv
// Host controller model: register pulses, chip-select toggles and the mode pin
`timescale 1ns/10ps
module fci_host_model (
    input wire ref_clk,
    input wire [7:0] reg_rdata,
    output reg sequencer_mode_select,
    output reg cs_n,
    output reg reg_wr_en,
    output reg reg_rd_en,
    output reg [14:0] reg_addr,
    output reg [7:0] reg_wdata
);
    // Idle: direct write mode, chip select high
    initial begin
        sequencer_mode_select = 1'b0;
        cs_n = 1'b1;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 15'h0000;
        reg_wdata = 8'h00;
    end
    // Released lines flip so a stale value can never pass for a fresh one
    task wr(input [14:0] a, input [7:0] d);
        begin
            @(negedge ref_clk);
            reg_addr = a;
            reg_wdata = d;
            reg_wr_en = 1'b1;
            @(negedge ref_clk);
            reg_wr_en = 1'b0;
            reg_addr = ~a;
            reg_wdata = ~d;
        end
    endtask
    task rd(input [14:0] a, output [7:0] d);
        begin
            @(negedge ref_clk);
            reg_addr = a;
            reg_rd_en = 1'b1;
            @(negedge ref_clk);
            reg_rd_en = 1'b0;
            reg_addr = ~a;
            @(negedge ref_clk);
            d = reg_rdata;
        end
    endtask
    // Low for one sampled cycle, then high; waits until the codes settle
    task pulse_cs;
        begin
            @(negedge ref_clk);
            cs_n = 1'b0;
            @(negedge ref_clk);
            cs_n = 1'b1;
            repeat (3) @(negedge ref_clk);
        end
    endtask
    task set_mode(input m);
        begin
            @(negedge ref_clk);
            sequencer_mode_select = m;
        end
    endtask
endmodule // fci_host_model

// ===== bench/fci_checker.sv
// Assertion checker bound to the filter code block ports
`timescale 1ns/10ps
module fci_checker (
    input wire ref_clk,
    input wire rst_n,
    input wire sequencer_mode_select,
    input wire cs_n,
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [14:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire [7:0] center_cap_code,
    input wire [7:0] bandwidth_cap_code,
    input wire [7:0] match_cap_code,
    input wire [6:0] sequence_pointer
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    reg [6:0] stop;
    reg [6:0] start;
    reg dir;
    reg interp;
    reg cs_q;
    wire rise = cs_n && !cs_q;
    wire [6:0] up = (sequence_pointer == stop) ? start : sequence_pointer + 7'h01;
    wire [6:0] dn = (sequence_pointer == start) ? stop : sequence_pointer - 7'h01;
    // Shadow fields; cs_q resets high so a reset release never reads as a rise
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop <= 7'h7F;
            start <= 7'h00;
            dir <= 1'b0;
            interp <= 1'b0;
            cs_q <= 1'b1;
        end else begin
            cs_q <= cs_n;
            if (reg_wr_en && reg_addr == 15'h0011) stop <= reg_wdata[6:0];
            if (reg_wr_en && reg_addr == 15'h0012) start <= reg_wdata[6:0];
            if (reg_wr_en && reg_addr == 15'h0013) dir <= reg_wdata[0];
            if (reg_wr_en && reg_addr == 15'h0050) interp <= reg_wdata[0];
        end
    end
    a_ptr_hold: assert property (!rise |=> $stable(sequence_pointer))
        else $error("pointer moved without a rise");
    a_ptr_reload: assert property (rise && !sequencer_mode_select |=>
        sequence_pointer == (dir ? stop : start)) else $error("bad reload");
    a_step_up: assert property (rise && sequencer_mode_select && !dir |=>
        sequence_pointer == $past(up)) else $error("bad up step");
    a_step_down: assert property (rise && sequencer_mode_select && dir |=>
        sequence_pointer == $past(dn)) else $error("bad down step");
    a_rb_center: assert property (reg_rd_en && reg_addr == 15'h0060 |=>
        reg_rdata == $past(center_cap_code)) else $error("bad centre readback");
    a_rb_bw: assert property (reg_rd_en && reg_addr == 15'h0061 |=>
        reg_rdata == $past(bandwidth_cap_code)) else $error("bad bandwidth readback");
    a_rb_match: assert property (reg_rd_en && reg_addr == 15'h0062 |=>
        reg_rdata == $past(match_cap_code)) else $error("bad match readback");
    a_ptr_read: assert property (reg_rd_en && reg_addr == 15'h0014 |=>
        reg_rdata == {1'b0, $past(sequence_pointer)}) else $error("bad pointer read");
    a_direct_code: assert property (reg_wr_en && reg_addr == 15'h0020 &&
        !sequencer_mode_select && !interp |-> ##2 center_cap_code == $past(reg_wdata, 2))
        else $error("direct load not applied");
    cover property (rise && sequencer_mode_select && !dir && sequence_pointer == stop);
    cover property (rise && sequencer_mode_select && dir && sequence_pointer == start);
    cover property (reg_wr_en && reg_addr == 15'h0050 && reg_wdata[0]);
endmodule // fci_checker
bind fci_filter_code_interp_sequencer fci_checker u_chk (.ref_clk, .rst_n,
    .sequencer_mode_select, .cs_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .reg_rdata, .center_cap_code, .bandwidth_cap_code, .match_cap_code, .sequence_pointer);

// ===== bench/fci_filter_code_interp_sequencer_tb.sv
// Self-checking bench of the filter code block
`timescale 1ns/10ps
`define FCI_CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module fci_filter_code_interp_sequencer_tb;
    reg ref_clk = 1'b0;
    reg rst_n = 1'b0;
    wire mode, cs_n, wr_en, rd_en;
    wire [14:0] addr;
    wire [7:0] wdata, rdata, cc, bc, mc;
    wire [6:0] ptr;
    int errors = 0;
    int compares = 0;
    int i, p, d, k, e;
    int cf [16] = '{218, 176, 142, 102, 75, 55, 42, 32, 24, 19, 1, 5, 39, 5, 25, 138};
    int xs [11] = '{0, 15, 16, 31, 32, 63, 100, 180, 224, 254, 255};
    logic [14:0] ra [5] = '{15'h0011, 15'h0012, 15'h0013, 15'h0014, 15'h0070};
    logic [7:0] rx [5] = '{8'h7F, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] rv, y;
    always #5 ref_clk = ~ref_clk;
    fci_host_model u_host (.ref_clk(ref_clk), .reg_rdata(rdata), .sequencer_mode_select(mode),
        .cs_n(cs_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata));
    fci_filter_code_interp_sequencer u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .sequencer_mode_select(mode), .cs_n(cs_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .center_cap_code(cc),
        .bandwidth_cap_code(bc), .match_cap_code(mc), .sequence_pointer(ptr));
    // Centre curve: 16-wide segments below 32, 32-wide ones up to 254, floor shifts
    function automatic [7:0] ref_y(input int x);
        int kk, en, sh;
        begin
            kk = (x < 32) ? x / 16 : x / 32 + 1;
            en = (x < 32) ? 16 * kk + 16 : 32 * kk;
            sh = (x < 32) ? 4 : 5;
            ref_y = (x >= 255) ? 8'(cf[9]) :
                8'(cf[kk + 1] + (((en - x) * (cf[kk] - cf[kk + 1])) >>> sh));
        end
    endfunction
    // Bandwidth or match curve from coefficient base b
    function automatic [7:0] ref_bm(input int yy, input int b);
        if (yy < 32) ref_bm = 8'(cf[b] + ((yy * (cf[b + 1] - cf[b])) >>> 5));
        else if (yy < 255)
            ref_bm = 8'(cf[b + 1] + (((yy - 32) * (cf[b + 2] - cf[b + 1]) * 295) >>> 16));
        else ref_bm = 8'(cf[b + 2]);
    endfunction
    task report_and_stop;
        begin
            if (errors == 0 && compares > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        #100_000;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk) rst_n = 1'b1;
        // Read-only places ignore writes; reset values and an unmapped read
        u_host.wr(15'h0014, 8'h55);
        u_host.wr(15'h0060, 8'h77);
        for (i = 0; i < 5; i++) begin
            u_host.rd(ra[i], rv);
            `FCI_CHECK(rv, rx[i])
        end
        for (i = 0; i < 3; i++) u_host.wr(15'h0020 + 15'(i), 8'h5A + 8'(i * 49));
        repeat (2) @(negedge ref_clk);
        `FCI_CHECK({cc, bc, mc}, 24'h5A_8BBC)
        for (i = 0; i < 3; i++) begin
            u_host.rd(15'h0060 + 15'(i), rv);
            `FCI_CHECK(rv, 8'h5A + 8'(i * 49))
        end
        // Second pass stores tuned mid values and a high value below mid
        u_host.wr(15'h0050, 8'h01);
        for (p = 0; p < 2; p++) begin
            for (i = 0; i < 11; i++) begin
                u_host.wr(15'h0020, 8'(xs[i]));
                repeat (3) @(negedge ref_clk);
                y = ref_y(xs[i]);
                `FCI_CHECK(cc, y)
                `FCI_CHECK(bc, ref_bm(y, 10))
                `FCI_CHECK(mc, ref_bm(y, 13))
            end
            cf[11] = 48;
            cf[12] = 16;
            cf[14] = 8;
            u_host.wr(15'h003B, 8'h30);
            u_host.wr(15'h003C, 8'h10);
            u_host.wr(15'h003E, 8'h08);
        end
        // Low trim near load 18; a top load then puts y under the knee
        cf[10] = 3;
        cf[13] = 7;
        u_host.wr(15'h003A, 8'h03);
        u_host.wr(15'h003D, 8'h07);
        for (i = 0; i < 2; i++) begin
            u_host.wr(15'h0020, i ? 8'hF0 : 8'h12);
            repeat (3) @(negedge ref_clk);
            y = ref_y(i ? 240 : 18);
            `FCI_CHECK({cc, bc, mc}, {y, ref_bm(y, 10), ref_bm(y, 13)})
        end
        // Breakpoint codes written back as direct loads with interpolation off
        u_host.wr(15'h0050, 8'h00);
        for (i = 0; i < 11; i++) begin
            y = ref_y(xs[i]);
            u_host.wr(15'h0020, y);
            u_host.wr(15'h0021, ref_bm(y, 10));
            u_host.wr(15'h0022, ref_bm(y, 13));
            repeat (2) @(negedge ref_clk);
            `FCI_CHECK({cc, bc, mc}, {y, ref_bm(y, 10), ref_bm(y, 13)})
        end
        // Table entries 0..3 and a start/stop window of 1..3, both directions
        u_host.wr(15'h0050, 8'h00);
        for (i = 0; i < 12; i++) u_host.wr(15'h0100 + 15'(i), 8'h10 * 8'(i % 3 + 1) + 8'(i / 3));
        u_host.wr(15'h0011, 8'h03);
        u_host.wr(15'h0012, 8'h01);
        for (d = 0; d < 2; d++) begin
            u_host.wr(15'h0013, 8'(d));
            u_host.pulse_cs();
            e = d ? 3 : 1;
            `FCI_CHECK(ptr, 7'(e))
            u_host.set_mode(1'b1);
            for (k = 0; k < 5; k++) begin
                u_host.pulse_cs();
                `FCI_CHECK({cc, bc, mc}, {8'h10, 8'h20, 8'h30} + {3{8'(e)}})
                e = d ? (e == 1 ? 3 : e - 1) : (e == 3 ? 1 : e + 1);
                `FCI_CHECK(ptr, 7'(e))
            end
            u_host.set_mode(1'b0);
        end
        u_host.pulse_cs();
        u_host.rd(15'h0014, rv);
        `FCI_CHECK(rv, 8'h03)
        report_and_stop();
    end
endmodule // fci_filter_code_interp_sequencer_tb
